// *** logic/snbbm_core.sv ***
// Serial NAND status, write-enable and bad-block remap command block.
// Assumes a mode-0 SPI host; array engine reports busy and completion.
//
// Contract
// RULE_01: ID read: 9F, dummy byte, three bytes
// RULE_02: Status read opcodes 0F/05 plus address byte
// RULE_03: Selected status byte shifted out MSB first
// RULE_04: Status read answered even while busy
// RULE_05: Status value repeats until chip select high
// RULE_06: Status write: opcode, address, data byte
// RULE_07: Only documented writable bits change
// RULE_08: Protect, top/bottom, ECC default one
// RULE_09: Opcode 06 sets write enable latch
// RULE_10: Remap refused while latch clear
// RULE_11: Opcode 04 clears write enable latch
// RULE_12: Latch cleared at reset and completions
// RULE_13: Remap: A1, logical then physical address
// RULE_14: Each remap adds link; twenty maximum
// RULE_15: Full table sets flag, rejects remaps
// RULE_16: Host never duplicates a block address
// RULE_17: Table read: A5, dummy, from clock 16
// RULE_18: Links output in order, 32 bits each
// RULE_19: Unused links read as zero
// RULE_20: Top logical bits carry link status
// RULE_21: Host scans factory bad block markers
// RULE_22: Short frames abort without side effects
`timescale 1ns/10ps
module snbbm_core
   import snbbm_pkg::*;
#(
   parameter int          NUM_LINKS    = 20,     // Remap table depth
   parameter int          REMAP_CYCLES = 16,     // Busy time of a remap
   parameter logic [7:0]  MFR_ID       = 8'h5A,  // Arbitrary value
   parameter logic [15:0] DEV_ID       = 16'hC3A5 // Arbitrary value
) (
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        spi_clk_i,
   input  wire logic        spi_cs_n_i,
   input  wire logic        spi_mosi_i,
   output logic             spi_miso_o,
   output logic             spi_miso_oe_o,
   input  wire logic        array_busy_i,
   input  wire logic        array_op_done_i,
   input  wire logic        prog_fail_i,
   input  wire logic        erase_fail_i,
   input  wire logic [1:0]  ecc_status_i,
   output logic [7:0]       prot_reg_o,
   output logic [7:0]       config_reg_o,
   output logic             write_enable_latch_o,
   output logic             remap_table_full_o,
   output logic             remap_busy_o,
   output logic             device_reset_o
);
   // Derived widths; the link counter must also hold the full table size
   localparam int CW = $clog2(NUM_LINKS + 1);   // Link count width
   localparam int IW = $clog2(NUM_LINKS);       // Link index width
   localparam logic [CW-1:0] LINKS_MAX  = CW'(NUM_LINKS);
   localparam logic [15:0]   RM_CYC_MAX = 16'(REMAP_CYCLES - 1);

   // Elaboration guard: table index must fit the output phase field
   if (NUM_LINKS < 2 || NUM_LINKS > 60 || REMAP_CYCLES < 1 || REMAP_CYCLES > 65535) begin : g_chk
      $error("snbbm_core: unsupported parameter values");
   end

   // Remap sequencer states; busy stands in for the non-volatile write time
   typedef enum logic [1:0] {RM_IDLE, RM_BUSY} snbbm_rm_e;

   snbbm_frame_if fr ();                  // Captured link fields
   wire  link_rst_n = resetn_i & ~spi_cs_n_i;  // Link logic idles with cs high

   logic          cs_s;                   // Synchronised chip select
   logic          cs_q;                   // Delayed copy for edge find
   logic [7:0]    prot;                   // Protection register
   logic [7:0]    cfg;                    // Configuration register
   logic          write_enable_latch;                    // Write enable latch
   logic          lut_full;               // Remap table full flag
   logic [CW-1:0] count;                  // Links established
   logic [15:0]   lba_tab [NUM_LINKS];    // Logical addresses
   logic [15:0]   pba_tab [NUM_LINKS];    // Physical addresses
   snbbm_rm_e     rm_state;               // Remap sequencer
   logic [15:0]   rm_timer;               // Remap busy countdown
   logic [7:0]    snap_prot;              // Frame-stable copies for link
   logic [7:0]    snap_cfg;
   logic [7:0]    snap_stat;
   logic [CW-1:0] snap_count;

   // Receiver on the link clock
   snbbm_rx u_rx (
      .spi_clk_i    (spi_clk_i),
      .resetn_i     (resetn_i),
      .link_rst_n_i (link_rst_n),
      .mosi_i       (spi_mosi_i),
      .fr           (fr)
   );

   // Chip select into the core clock
   snbbm_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
      .clk_i    (mclk_i),
      .resetn_i (resetn_i),
      .d_i      (spi_cs_n_i),
      .q_o      (cs_s)
   );

   // Edge finder reads only the second stage
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) cs_q <= 1'b1;
      else           cs_q <= cs_s;
   end

   // Frame end: fields stay still because the link clock has stopped
   wire cs_rise = cs_s & ~cs_q;
   wire [7:0] op = fr.opcode;
   wire [3:0] rsel = fr.addr[7:4];

   // RULE_22 length gate
   wire ok_opc   = fr.nbits >= NB_OPC;
   wire ok_ws    = fr.nbits >= NB_WS;
   wire ok_remap = fr.nbits >= NB_REMAP;

   // Instruction decode at frame end
   wire do_wren  = cs_rise & ok_opc & (op == OP_WREN);
   wire do_wrdis = cs_rise & ok_opc & (op == OP_WRDIS);
   wire do_reset = cs_rise & ok_opc & (op == OP_DEV_RESET);
   // RULE_06 status write decode
   wire do_ws    = cs_rise & ok_ws & ((op == OP_STAT_WR_A) | (op == OP_STAT_WR_B));
   wire ws_prot  = do_ws & (rsel == SREG_PROT);
   wire ws_cfg   = do_ws & (rsel == SREG_CFG);
   // RULE_10 RULE_15 remap acceptance
   wire do_remap = cs_rise & ok_remap & (op == OP_REMAP) & write_enable_latch & ~lut_full
                   & (rm_state == RM_IDLE);
   wire remap_done = (rm_state == RM_BUSY) & (rm_timer == '0);

   // RULE_07 masked merge
   wire [7:0] next_prot = (prot & ~PROT_WR_MASK) | (fr.data & PROT_WR_MASK);
   wire [7:0] next_cfg  = (cfg & ~CFG_WR_MASK) | (fr.data & CFG_WR_MASK);

   // RULE_09 RULE_11 RULE_12 latch; setting wins over a same-cycle clear
   wire wel_clr  = do_wrdis | do_reset | array_op_done_i | remap_done;
   wire next_wel = do_wren | (write_enable_latch & ~wel_clr);

   // Live status byte
   wire busy = array_busy_i | (rm_state == RM_BUSY);
   wire [7:0] stat_live = (8'(busy) << STAT_BUSY) | (8'(write_enable_latch) << STAT_WEL)
                        | (8'(prog_fail_i) << STAT_PFAIL) | (8'(erase_fail_i) << STAT_EFAIL)
                        | (8'(ecc_status_i) << STAT_ECC_LSB) | (8'(lut_full) << STAT_LUTF);

   // Status and latch registers
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // RULE_08 power-up defaults
         prot <= PROT_RST;
         cfg  <= CFG_RST;
         write_enable_latch  <= 1'b0;
      end else begin
         write_enable_latch <= next_wel;
         if (ws_prot) prot <= next_prot;
         if (ws_cfg)  cfg  <= next_cfg;
      end
   end

   // Remap sequencer: link written at start, counted once busy ends
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rm_state <= RM_IDLE;
         rm_timer <= '0;
         count    <= '0;
         lut_full <= 1'b0;
      end else begin
         case (rm_state)
            RM_IDLE: begin
               if (do_remap) begin
                  rm_state <= RM_BUSY;
                  rm_timer <= RM_CYC_MAX;
               end
            end
            RM_BUSY: begin
               if (remap_done) begin
                  rm_state <= RM_IDLE;
                  // RULE_14 link counted
                  count <= count + CW'(1);
                  // RULE_15 full flag is set-only
                  if (count == LINKS_MAX - CW'(1)) lut_full <= 1'b1;
               end else begin
                  rm_timer <= rm_timer - 16'h0001;
               end
            end
            default: rm_state <= RM_IDLE;
         endcase
      end
   end

   // Table storage; retention across power cycles is outside this logic
   always_ff @(posedge mclk_i) begin
      if (do_remap) begin
         // RULE_13 RULE_20 store pair, mark link enabled
         lba_tab[count[IW-1:0]] <= {LBA_VALID, fr.arg[29:16]};
         pba_tab[count[IW-1:0]] <= fr.arg[15:0];
      end
   end

   // Frame-stable copies: updated only while chip select is high
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         snap_prot  <= PROT_RST;
         snap_cfg   <= CFG_RST;
         snap_stat  <= '0;
         snap_count <= '0;
      end else if (cs_s) begin
         // RULE_04 taken regardless of busy
         snap_prot  <= prot;
         snap_cfg   <= cfg;
         snap_stat  <= stat_live;
         snap_count <= count;
      end
   end

   // Core-side outputs from flops; remap busy is decoded from the sequencer state
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         device_reset_o <= 1'b0;
      end else begin
         device_reset_o <= do_reset;
      end
   end
   assign prot_reg_o           = prot;
   assign config_reg_o         = cfg;
   assign write_enable_latch_o = write_enable_latch;
   assign remap_table_full_o   = lut_full;
   assign remap_busy_o         = rm_state == RM_BUSY;

   // Snapshots, not live registers, feed the status bytes and link count to the link so no byte moves mid-shift
   // Link-side response selection
   wire        in_resp = fr.cnt >= CNT_RESP;
   wire [10:0] pos     = fr.cnt - CNT_RESP;
   wire        is_stat = (op == OP_STAT_RD_A) | (op == OP_STAT_RD_B);
   wire        is_id   = op == OP_READ_ID;
   wire        is_tab  = op == OP_TABLE_RD;
   // RULE_02 register select
   wire [7:0]  sel_stat = (rsel == SREG_PROT) ? snap_prot :
                          (rsel == SREG_CFG)  ? snap_cfg  :
                          (rsel == SREG_STAT) ? snap_stat : 8'h00;
   // RULE_01 identity padded to a word, zero after
   wire [31:0] id_word  = {MFR_ID, DEV_ID, 8'h00};
   wire        id_bit   = (pos[10:5] == '0) & id_word[~pos[4:0]];
   // RULE_18 link index advances every 32 bits
   wire [5:0]  link_idx = pos[10:5];
   // RULE_19 unused positions read zero
   wire        link_used = 7'(link_idx) < 7'(snap_count);
   wire [31:0] link_word = link_used ?
               {lba_tab[link_idx[IW-1:0]], pba_tab[link_idx[IW-1:0]]} : 32'h0000_0000;
   // RULE_03 RULE_05 byte repeats via low phase bits
   wire        resp_bit = is_stat ? sel_stat[~pos[2:0]] :
                          is_id   ? id_bit :
                          is_tab  ? link_word[~pos[4:0]] : 1'b0;
   wire        resp_on  = in_resp & (is_stat | is_id | is_tab);

   // Output and enable both drop at once when chip select rises
   // RULE_17 drive changes on falling edges from clock 16
   always_ff @(negedge spi_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         spi_miso_o    <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else begin
         spi_miso_o    <= resp_bit;
         spi_miso_oe_o <= resp_on;
      end
   end

   // Checks on the core clock
   property p_wel_set;
      @(posedge mclk_i) disable iff (!resetn_i)
      do_wren |=> write_enable_latch [*2];
   endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch not set"); // RULE_09

   property p_wel_clr;
      @(posedge mclk_i) disable iff (!resetn_i)
      do_wrdis && !do_wren |=> !write_enable_latch;
   endproperty
   a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared"); // RULE_11

   property p_done_clr;
      @(posedge mclk_i) disable iff (!resetn_i)
      (array_op_done_i || remap_done) && !do_wren |=> !write_enable_latch_o;
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("completion kept latch"); // RULE_12

   property p_refuse;
      @(posedge mclk_i) disable iff (!resetn_i)
      cs_rise && op == OP_REMAP && (!write_enable_latch || lut_full) && rm_state == RM_IDLE
      |=> rm_state == RM_IDLE ##1 $stable(count);
   endproperty
   a_refuse: assert property (p_refuse) else $error("remap not refused"); // RULE_10

   // Helper count of busy cycles; keeps the length check bounded for long remaps
   logic [16:0] remap_len;                // Wide enough for the longest remap
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         remap_len <= '0;
      end else if (do_remap) begin
         remap_len <= '0;
      end else if (remap_busy_o) begin
         remap_len <= remap_len + 17'h00001;
      end
   end

   // Busy lasts exactly the configured remap time
   property p_remap_len;
      @(posedge mclk_i) disable iff (!resetn_i)
      $fell(remap_busy_o) |-> remap_len == 17'(REMAP_CYCLES);
   endproperty
   a_remap_len: assert property (p_remap_len) else $error("remap busy length wrong"); // RULE_14

   property p_full;
      @(posedge mclk_i) disable iff (!resetn_i)
      $rose(lut_full) |-> count == LINKS_MAX && $past(remap_done);
   endproperty
   a_full: assert property (p_full) else $error("full flag wrong"); // RULE_15

   property p_mask;
      @(posedge mclk_i) disable iff (!resetn_i)
      ws_cfg |=> (cfg & ~CFG_WR_MASK) == ($past(cfg) & ~CFG_WR_MASK)
                 && (cfg & CFG_WR_MASK) == ($past(fr.data) & CFG_WR_MASK);
   endproperty
   a_mask: assert property (p_mask) else $error("read-only bits changed"); // RULE_07

   property p_abort;
      @(posedge mclk_i) disable iff (!resetn_i)
      cs_rise && !ok_opc |=> $stable(write_enable_latch) && $stable(prot) && $stable(cfg) && $stable(count);
   endproperty
   a_abort: assert property (p_abort) else $error("short frame acted"); // RULE_22

   // Checks on the link clock
   property p_oe_window;
      @(negedge spi_clk_i) disable iff (!link_rst_n)
      spi_miso_oe_o |-> fr.cnt >= CNT_RESP && (is_stat || is_id || is_tab);
   endproperty
   a_oe_window: assert property (p_oe_window) else $error("output outside answer"); // RULE_03

   c_wel_set:  cover property (@(posedge mclk_i) disable iff (!resetn_i) do_wren);
   c_remap:    cover property (@(posedge mclk_i) disable iff (!resetn_i) remap_done);
   c_full:     cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(lut_full));
   c_stat_out: cover property (@(negedge spi_clk_i) disable iff (!link_rst_n)
                               spi_miso_oe_o && is_stat);
endmodule : snbbm_core

// *** logic/snbbm_rx.sv ***
// Link-side receiver: counts clocks and captures instruction fields.
// Assumes the serial clock only toggles while chip select is low.
`timescale 1ns/10ps
module snbbm_rx
   import snbbm_pkg::*;
(
   input  wire logic   spi_clk_i,
   input  wire logic   resetn_i,
   input  wire logic   link_rst_n_i,
   input  wire logic   mosi_i,
   snbbm_frame_if.rx   fr
);
   logic [7:0]  sh;                              // Byte shifter
   wire  [7:0]  next_sh  = {sh[6:0], mosi_i};    // Byte with new bit
   wire  [31:0] next_arg = {fr.arg[30:0], mosi_i};

   // Frame clock counter; restarts at every chip select
   always_ff @(posedge spi_clk_i or negedge link_rst_n_i) begin
      if (!link_rst_n_i) begin
         fr.cnt <= '0;
      end else if (fr.cnt == CNT_WRAP) begin
         // Wrap onto a byte boundary so repeated reads keep phase
         fr.cnt <= CNT_RESP;
      end else begin
         fr.cnt <= fr.cnt + 11'h001;
      end
   end

   // Fields survive chip select high so the core can read them after
   always_ff @(posedge spi_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sh        <= '0;
         fr.arg    <= '0;
         fr.nbits  <= '0;
         fr.opcode <= '0;
         fr.addr   <= '0;
         fr.data   <= '0;
      end else begin
         sh     <= next_sh;
         fr.arg <= next_arg;
         // RULE_22 frame length kept
         fr.nbits <= (fr.cnt == '0) ? 6'h01 :
                     (fr.nbits >= NB_MAX) ? NB_MAX : fr.nbits + 6'h01;
         if (fr.cnt == CNT_OPC_LAST)  fr.opcode <= next_sh;
         if (fr.cnt == CNT_ADDR_LAST) fr.addr   <= next_sh;
         if (fr.cnt == CNT_DATA_LAST) fr.data   <= next_sh;
      end
   end
endmodule : snbbm_rx

// *** logic/snbbm_sync.sv ***
// Two-flop level synchroniser with a constant reset value.
// Assumes the input is a level that stays long enough to be seen.
`timescale 1ns/10ps
module snbbm_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;   // First stage, read only by q_o

   // Two stages, nothing taps the first
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta <= RST_VAL;
         q_o  <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : snbbm_sync

// *** pkg/snbbm_frame_if.sv ***
// Captured frame fields passed from the link receiver to the core.
// Assumes all fields live on the link clock; the core reads them quasi-static.
`timescale 1ns/10ps
interface snbbm_frame_if;
   logic [10:0] cnt;     // Posedges seen in this frame
   logic [5:0]  nbits;   // Frame length, saturating
   logic [7:0]  opcode;  // First byte
   logic [7:0]  addr;    // Second byte
   logic [7:0]  data;    // Third byte
   logic [31:0] arg;     // Bytes two to five
   modport rx   (output cnt, nbits, opcode, addr, data, arg);
   modport core (input  cnt, nbits, opcode, addr, data, arg);
endinterface : snbbm_frame_if

// *** pkg/snbbm_pkg.sv ***
// Shared constants for the serial NAND status and remap command block.
// Assumes a single-bit SPI link, mode 0, opcodes sampled MSB first.
package snbbm_pkg;
   // Instruction codes
   localparam logic [7:0] OP_READ_ID   = 8'h9F;
   localparam logic [7:0] OP_STAT_RD_A = 8'h0F;
   localparam logic [7:0] OP_STAT_RD_B = 8'h05;
   localparam logic [7:0] OP_STAT_WR_A = 8'h1F;
   localparam logic [7:0] OP_STAT_WR_B = 8'h01;
   localparam logic [7:0] OP_WREN      = 8'h06;
   localparam logic [7:0] OP_WRDIS     = 8'h04;
   localparam logic [7:0] OP_REMAP     = 8'hA1;
   localparam logic [7:0] OP_TABLE_RD  = 8'hA5;
   localparam logic [7:0] OP_DEV_RESET = 8'hFF;
   // Register select, upper nibble of the address byte
   localparam logic [3:0] SREG_PROT = 4'hA;
   localparam logic [3:0] SREG_CFG  = 4'hB;
   localparam logic [3:0] SREG_STAT = 4'hC;
   // Protection byte: [7:6] mode, [5:2] block protect, [1] top/bottom, [0] wp enable
   localparam logic [7:0] PROT_WR_MASK = 8'hFF;
   localparam logic [7:0] PROT_RST     = 8'h3E;
   // Config byte: [7] otp lock, [6] otp enable, [5] prot lock, [4] ecc enable, [3] buffer
   localparam logic [7:0] CFG_WR_MASK  = 8'hF8;
   localparam logic [7:0] CFG_RST      = 8'h10;
   // Status byte bit positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_WEL  = 1;
   localparam int STAT_PFAIL = 2;
   localparam int STAT_EFAIL = 3;
   localparam int STAT_ECC_LSB = 4;
   localparam int STAT_LUTF = 6;
   // Link bit counts (posedges seen in the frame)
   localparam logic [10:0] CNT_OPC_LAST  = 11'h007;
   localparam logic [10:0] CNT_ADDR_LAST = 11'h00F;
   localparam logic [10:0] CNT_DATA_LAST = 11'h017;
   localparam logic [10:0] CNT_ARG_LAST  = 11'h027;
   localparam logic [10:0] CNT_RESP      = 11'h010;
   localparam logic [10:0] CNT_WRAP      = 11'h7FF;
   // Frame lengths needed before an instruction may execute
   localparam logic [5:0] NB_OPC   = 6'h08;
   localparam logic [5:0] NB_WS    = 6'h18;
   localparam logic [5:0] NB_REMAP = 6'h28;
   localparam logic [5:0] NB_MAX   = 6'h28;
   // Link status code stored in the top logical address bits
   localparam logic [1:0] LBA_VALID = 2'h2;
endpackage : snbbm_pkg

// *** verif/snbbm_core_tb.sv ***
// Self-checking bench for the serial NAND status and remap block.
// Assumes the host model owns the link pins; core inputs change on mclk rise.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module snbbm_core_tb import snbbm_pkg::*;;
   localparam int          NL  = 4;        // Short table keeps the run brief
   localparam int          RC  = 8;        // Short remap busy time
   localparam logic [7:0]  MFR = 8'h3C;    // Arbitrary value
   localparam logic [15:0] DEV = 16'h9D17; // Arbitrary value
   logic        mclk_i = 1'b0;             // Core clock
   logic        resetn_i = 1'b0;           // Async reset, active low
   logic        spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic        busy = 1'b0, done = 1'b0, pfail = 1'b0, efail = 1'b0;
   logic [1:0]  ecc = 2'b00;               // Array ECC result
   logic [7:0]  prot, cfg, v;
   logic        write_enable_latch, full, rbusy, dev_rst;
   logic [191:0] r;                        // Captured response
   int          fails = 0, check_count = 0, rst_seen = 0, busy_cycles = 0;

   // Core clock, 4 ns period
   always #2 mclk_i = ~mclk_i;

   snbbm_core #(.NUM_LINKS(NL), .REMAP_CYCLES(RC), .MFR_ID(MFR), .DEV_ID(DEV)) i_snbbm_core (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n),
      .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso), .spi_miso_oe_o(spi_miso_oe),
      .array_busy_i(busy), .array_op_done_i(done), .prog_fail_i(pfail),
      .erase_fail_i(efail), .ecc_status_i(ecc), .prot_reg_o(prot), .config_reg_o(cfg),
      .write_enable_latch_o(write_enable_latch), .remap_table_full_o(full), .remap_busy_o(rbusy),
      .device_reset_o(dev_rst));

   snbbm_host i_snbbm_host (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n),
      .spi_mosi_o(spi_mosi), .spi_miso_i(spi_miso), .spi_miso_oe_i(spi_miso_oe));

   // Count reset pulses, one cycle wide
   always @(posedge mclk_i) if (dev_rst === 1'b1) rst_seen++;

   // Count core cycles spent in remap busy
   always @(posedge mclk_i) if (rbusy === 1'b1) busy_cycles++;

   // Verdict and end of run
   task test_done;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task rd(input logic [7:0] op, input logic [7:0] a, output logic [7:0] d);
      i_snbbm_host.xfer({op, a, 8'h00}, 24, r);
      d = r[7:0];
   endtask : rd

   task cmd(input logic [7:0] op);
      i_snbbm_host.xfer({184'h0, op}, 8, r);
   endtask : cmd

   task remap(input logic [15:0] logical_block_addr, input logic [15:0] physical_block_addr);
      int n;
      n = 0;
      i_snbbm_host.xfer({OP_REMAP, logical_block_addr, physical_block_addr}, 40, r);
      // Bounded wait for the remap to finish
      while (rbusy !== 1'b0 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 100) begin
         fails++;
         test_done();
      end
   endtask : remap

   initial begin
      repeat (16) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      // Both read opcodes, all three registers, power-up values
      for (int i = 0; i < 2; i++) begin
         rd(i ? OP_STAT_RD_B : OP_STAT_RD_A, 8'hA0, v); `CHK(v, 8'h3E)
         rd(i ? OP_STAT_RD_B : OP_STAT_RD_A, 8'hB0, v); `CHK(v, 8'h10)
         rd(i ? OP_STAT_RD_B : OP_STAT_RD_A, 8'hC0, v); `CHK(v, 8'h00)
      end
      i_snbbm_host.xfer({OP_STAT_RD_A, 8'hA0, 24'h0}, 40, r);
      `CHK(r[23:0], 24'h3E3E3E)
      i_snbbm_host.xfer({OP_READ_ID, 8'h00, 24'h0}, 40, r);
      `CHK(r[23:0], {MFR, DEV})
      $display("test defaults and id done");
      // Writable bits only; a short write does nothing
      i_snbbm_host.xfer({OP_STAT_WR_A, 8'hA0, 8'hC1}, 24, r);
      `CHK(prot, 8'hC1)
      i_snbbm_host.xfer({OP_STAT_WR_B, 8'hB0, 8'hFF}, 24, r);
      rd(OP_STAT_RD_A, 8'hB0, v); `CHK(v, 8'hF8)
      `CHK(cfg, 8'hF8)
      i_snbbm_host.xfer({OP_STAT_WR_A, 8'hC0, 8'hFF}, 24, r);
      rd(OP_STAT_RD_A, 8'hC0, v); `CHK(v, 8'h00)
      i_snbbm_host.xfer({OP_STAT_WR_A, 8'hA0}, 16, r);
      `CHK(prot, 8'hC1)
      $display("test status write done");
      // Latch set and clear
      cmd(OP_WREN); `CHK(write_enable_latch, 1'b1)
      rd(OP_STAT_RD_B, 8'hC0, v); `CHK(v, 8'h02)
      cmd(OP_WRDIS); `CHK(write_enable_latch, 1'b0)
      // A frame cut inside the opcode changes nothing
      i_snbbm_host.xfer({184'h0, OP_WREN}, 4, r);
      `CHK(write_enable_latch, 1'b0)
      // Refused without latch, aborted when cut short
      remap(16'h0012, 16'h0345);
      cmd(OP_WREN);
      i_snbbm_host.xfer({OP_REMAP, 16'h0013}, 24, r);
      `CHK(write_enable_latch, 1'b1)
      // table scanned before any link is made
      i_snbbm_host.xfer({OP_TABLE_RD, 8'h00, 32'h0}, 48, r);
      `CHK(r[31:0], 32'h0)
      $display("test latch and refusal done");
      // Fill the table with distinct blocks
      for (int k = 0; k < NL; k++) begin
         cmd(OP_WREN);
         `CHK(full, 1'b0)
         remap(16'h0010 + 16'(k), 16'h0100 + 16'(k));
         `CHK(write_enable_latch, 1'b0)
      end
      `CHK(full, 1'b1)
      rd(OP_STAT_RD_A, 8'hC0, v); `CHK(v, 8'h40)
      i_snbbm_host.xfer({OP_TABLE_RD, 8'h00, 160'h0}, 16 + 32 * (NL + 1), r);
      for (int k = 0; k < NL; k++)
         `CHK(r[32 * (NL - k) +: 32], {16'h8010 + 16'(k), 16'h0100 + 16'(k)})
      `CHK(r[31:0], 32'h0)
      cmd(OP_WREN);
      remap(16'h0020, 16'h0200);
      `CHK(write_enable_latch, 1'b1)
      `CHK(busy_cycles, NL * RC)
      $display("test remap table done");
      // Live status while the array is busy
      @(posedge mclk_i);
      busy  <= 1'b1;
      pfail <= 1'b1;
      ecc   <= 2'b10;
      rd(OP_STAT_RD_A, 8'hC0, v); `CHK(v, 8'h67)
      @(posedge mclk_i);
      done <= 1'b1;
      busy <= 1'b0;
      @(posedge mclk_i);
      done <= 1'b0;
      repeat (2) @(posedge mclk_i);
      `CHK(write_enable_latch, 1'b0)
      // Soft reset clears the latch
      cmd(OP_WREN); `CHK(write_enable_latch, 1'b1)
      cmd(OP_DEV_RESET);
      `CHK(write_enable_latch, 1'b0)
      `CHK(rst_seen, 1)
      $display("test busy and reset done");
      test_done();
   end
endmodule : snbbm_core_tb

// *** verif/snbbm_host.sv ***
// Behavioural SPI host that stands on the far side of the command block.
// Assumes mode 0 and a 12 ns serial clock that runs only inside frames.
`timescale 1ns/10ps
module snbbm_host (
   output logic spi_clk_o,      // Serial clock, idle low
   output logic spi_cs_n_o,     // Chip select, active low
   output logic spi_mosi_o,     // Serial data towards the device
   input  wire logic spi_miso_i,   // Serial data from the device
   input  wire logic spi_miso_oe_i // Device drives the data line
);
   initial begin
      spi_clk_o  = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end

   // One whole frame: n bits from tx, right aligned, MSB first
   task automatic xfer(input logic [191:0] tx, input int n, output logic [191:0] rx);
      rx = '0;
      // Step off the core clock edges so no pin moves as it samples
      #1;
      spi_cs_n_o = 1'b0;
      #6;
      // change on fall, sample on rise
      for (int i = n - 1; i >= 0; i--) begin
         spi_mosi_o = tx[i];
         #6 spi_clk_o = 1'b1;
         // Released line must never pass for data
         rx = {rx[190:0], spi_miso_oe_i ? spi_miso_i : 1'bx};
         #6 spi_clk_o = 1'b0;
      end
      #6 spi_cs_n_o = 1'b1;
      // Idle data line carries no stale value
      spi_mosi_o = ~spi_mosi_o;
      // Gap well above the four core cycles asked between frames
      #60;
   endtask : xfer
endmodule : snbbm_host
